// file: iorm_pkg.sv
// Purpose: Shared constants and types of the I/O resource map block
// Assumes: Configuration index space is eight bits wide
// Notes:   All configuration registers reset to zero

// ************************************************************
// Package
// ************************************************************
package iorm_pkg;

  // Configuration register indexes
  localparam logic [7:0] IDX_RSVD_21   = 8'h21;
  localparam logic [7:0] IDX_SW_SEL    = 8'h22;
  localparam logic [7:0] IDX_PAR_BASE  = 8'h23;
  localparam logic [7:0] IDX_SER1_BASE = 8'h24;
  localparam logic [7:0] IDX_SER2_BASE = 8'h25;
  localparam logic [7:0] IDX_DMA_SEL   = 8'h26;
  localparam logic [7:0] IDX_IRQ_SEL   = 8'h27;
  localparam logic [7:0] IDX_SER_IRQ   = 8'h28;

  // Reset values
  localparam logic [7:0] RST_INDEX     = 8'h00;
  localparam logic [7:0] RST_SW_SEL    = 8'h00;
  localparam logic [7:0] RST_PAR_BASE  = 8'h00;
  localparam logic [7:0] RST_SER1_BASE = 8'h00;
  localparam logic [7:0] RST_SER2_BASE = 8'h00;
  localparam logic [7:0] RST_DMA_SEL   = 8'h00;
  localparam logic [7:0] RST_IRQ_SEL   = 8'h00;
  localparam logic [7:0] RST_SER_IRQ   = 8'h00;
  localparam logic [7:0] RD_ZERO       = 8'h00;

  // Writable bit masks
  localparam logic [7:0] SW_SEL_MASK   = 8'h3F;
  localparam logic [7:0] SER_BASE_MASK = 8'hFE;

  // Highest DMA code that names a channel
  localparam logic [3:0] DMA_CODE_MAX  = 4'h3;

  typedef enum logic [1:0] {
    PM_COMPAT,
    PM_BIDIR,
    PM_EPP,
    PM_ECP
  } iorm_pmode_t;

endpackage : iorm_pkg

// file: iorm_cfg_if.sv
// Purpose: Carries stored configuration to decode and routing logic
// Assumes: Single clock domain
// Notes:   Register file drives, consumers only read
`timescale 1ns/100ps

interface iorm_cfg_if;
  logic [7:0] par_base;
  logic [7:0] ser1_base;
  logic [7:0] ser2_base;
  logic [7:0] dma_sel;
  logic [7:0] irq_sel;
  logic [7:0] ser_irq_sel;

  modport src (
    output par_base,
    output ser1_base,
    output ser2_base,
    output dma_sel,
    output irq_sel,
    output ser_irq_sel
  );

  modport dst (
    input par_base,
    input ser1_base,
    input ser2_base,
    input dma_sel,
    input irq_sel,
    input ser_irq_sel
  );
endinterface : iorm_cfg_if

// file: iorm_decode.sv
// Purpose: Base address decode of parallel and serial ports
// Assumes: Address and chip select are synchronous to clk
// Notes:   Selects are registered, one cycle behind the address
`timescale 1ns/100ps

module iorm_decode (
  input  wire logic               clk,
  input  wire logic               srst,
  iorm_cfg_if.dst                 cfg,
  input  wire logic               cs_n,
  input  wire logic [10:2]        addr,
  input  wire iorm_pkg::iorm_pmode_t mode,
  output logic                    par_cs_q,
  output logic                    par_upper_q,
  output logic                    ser1_cs_q,
  output logic                    ser2_cs_q
);

  // ************************************************************
  // Match terms
  // ************************************************************
  wire par_on  = |cfg.par_base[7:6];                        // [RULE_07]
  wire par_m4  = addr[9:2] == cfg.par_base;                 // [RULE_05]
  wire par_m8  = addr[9:3] == cfg.par_base[7:1];            // [RULE_06]
  wire is_epp  = mode == iorm_pkg::PM_EPP;
  wire is_ecp  = mode == iorm_pkg::PM_ECP;
  wire par_mt  = is_epp ? par_m8 : par_m4;
  wire a10_ok  = is_ecp | ~addr[10];                        // [RULE_08] [RULE_09]
  wire par_hit = ~cs_n & par_on & par_mt & a10_ok;
  wire s1_on   = |cfg.ser1_base[7:6];
  wire s2_on   = |cfg.ser2_base[7:6];
  wire s1_hit  = ~cs_n & ~addr[10] & s1_on &
                 (addr[9:3] == cfg.ser1_base[7:1]);          // [RULE_11]
  wire s2_hit  = ~cs_n & ~addr[10] & s2_on &
                 (addr[9:3] == cfg.ser2_base[7:1]);          // [RULE_13]

  always_ff @(posedge clk) begin
    if (srst) begin
      par_cs_q    <= 1'b0;
      par_upper_q <= 1'b0;
      ser1_cs_q   <= 1'b0;
      ser2_cs_q   <= 1'b0;
    end else begin
      par_cs_q    <= par_hit;
      par_upper_q <= par_hit & is_ecp & addr[10];           // [RULE_09]
      ser1_cs_q   <= s1_hit;
      ser2_cs_q   <= s2_hit;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  par_off_a: assert property (!par_on |=> !par_cs_q) // [RULE_07]
    else $error("parallel decode active while disabled");
  par_a10_a: assert property (!is_ecp && addr[10] |=> !par_cs_q) // [RULE_08]
    else $error("parallel decode with A10 high");
  ser_off_a: assert property ((!s1_on |=> !ser1_cs_q) and // [RULE_11]
                              (!s2_on |=> !ser2_cs_q))
    else $error("serial decode active while disabled");
  ser_cs_a: assert property (cs_n |=> !ser1_cs_q && !ser2_cs_q) // [RULE_13]
    else $error("serial decode without chip select");

endmodule : iorm_decode

// file: iorm_route.sv
// Purpose: DMA request and interrupt line routing
// Assumes: Function requests are synchronous to clk
// Notes:   Enables are active low; high means the pin floats
`timescale 1ns/100ps

module iorm_route (
  input  wire logic        clk,
  input  wire logic        srst,
  iorm_cfg_if.dst          cfg,
  input  wire logic        floppy_drq,
  input  wire logic        par_drq,
  input  wire logic        floppy_irq,
  input  wire logic        par_irq,
  input  wire logic        ser1_irq,
  input  wire logic        ser2_irq,
  output logic [3:0]       dma_q,
  output logic [3:0]       dma_oe_n_q,
  output logic [15:1]      irq_q,
  output logic [15:1]      irq_oe_n_q
);

  // ************************************************************
  // DMA channels
  // ************************************************************
  // Codes above the last channel match no channel and leave it floating
  for (genvar ch = 0; ch < 4; ch++) begin : g_dma
    localparam logic [3:0] CODE = 4'(ch);
    wire f_sel = cfg.dma_sel[7:4] == CODE;                  // [RULE_15] [RULE_19]
    wire p_sel = cfg.dma_sel[3:0] == CODE;
    wire drv   = f_sel | p_sel;
    wire val   = (f_sel & floppy_drq) | (p_sel & par_drq);
    always_ff @(posedge clk) begin
      if (srst) begin
        dma_q[ch]      <= 1'b0;
        dma_oe_n_q[ch] <= 1'b1;
      end else begin
        dma_q[ch]      <= val;
        dma_oe_n_q[ch] <= ~drv;                             // [RULE_16]
      end
    end
  end

  // ************************************************************
  // Interrupt lines
  // ************************************************************
  // Sharing one line is unsupported; requests are simply ORed
  for (genvar ln = 1; ln < 16; ln++) begin : g_irq
    localparam logic [3:0] CODE = 4'(ln);
    wire f_sel = cfg.irq_sel[7:4] == CODE;                  // [RULE_17]
    wire p_sel = cfg.irq_sel[3:0] == CODE;
    wire s1    = cfg.ser_irq_sel[7:4] == CODE;              // [RULE_20]
    wire s2    = cfg.ser_irq_sel[3:0] == CODE;
    wire drv   = f_sel | p_sel | s1 | s2;
    wire val   = (f_sel & floppy_irq) | (p_sel & par_irq) |
                 (s1 & ser1_irq) | (s2 & ser2_irq);
    always_ff @(posedge clk) begin
      if (srst) begin
        irq_q[ln]      <= 1'b0;
        irq_oe_n_q[ln] <= 1'b1;
      end else begin
        irq_q[ln]      <= val;
        irq_oe_n_q[ln] <= ~drv;                             // [RULE_18]
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  dma_none_a: assert property ( // [RULE_19]
    cfg.dma_sel[7:4] > iorm_pkg::DMA_CODE_MAX &&
    cfg.dma_sel[3:0] > iorm_pkg::DMA_CODE_MAX
    |=> dma_oe_n_q == 4'hF)
    else $error("DMA pin driven with no channel selected");
  irq_none_a: assert property ( // [RULE_18]
    cfg.irq_sel == 8'h00 && cfg.ser_irq_sel == 8'h00
    |=> irq_oe_n_q == 15'h7FFF)
    else $error("interrupt pin driven with no line selected");

endmodule : iorm_route

// file: iorm_top.sv
// Purpose: Configuration registers mapping functions onto I/O resources
// Assumes: Host bus master logic runs on clk
// Notes:   Data port access needs configuration state and a loaded index
//
// How it works
// (RULE_01) Index 21 ignores writes and always reads as zero.
// (RULE_02) Index 22 holds software IRQ and DMA indicators, top bits reserved.
// (RULE_03) Software indicators never touch the real DMA or IRQ routing.
// (RULE_04) Access only in configuration state with the index loaded first.
// (RULE_05) Without EPP, parallel base decodes on 4-byte boundaries.
// (RULE_06) With EPP, parallel base decodes on 8-byte boundaries.
// (RULE_07) Parallel base holds address bits 9..2; top bits zero disable.
// (RULE_08) Parallel decode needs chip select low and A10 low.
// (RULE_09) In ECP mode A10 selects the upper register group.
// (RULE_10) Serial one base holds bits 9..3, bit 0 kept zero.
// (RULE_11) Serial one decode off when top bits zero, else cs and A10 low.
// (RULE_12) Serial two base behaves like serial one base.
// (RULE_13) Serial two decode off when top bits zero, else cs and A10 low.
// (RULE_14) All base and select registers reset to zero.
// (RULE_15) DMA select nibbles route floppy and parallel; codes 0..3 channels.
// (RULE_16) Unselected DMA request pins float.
// (RULE_17) IRQ select nibbles route floppy and parallel; 0 none, 1..15 lines.
// (RULE_18) Unselected interrupt pins float.
// (RULE_19) DMA codes 4 to 14 select no channel.
// (RULE_20) Serial ports route interrupts by a nibble each, same encoding.
`timescale 1ns/100ps

module iorm_top (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cfg_state,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_index_sel,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  output logic             io_rd_valid,
  input  wire logic        chip_select_n,
  input  wire logic [10:2] host_addr,
  input  wire logic [1:0]  par_mode,
  input  wire logic        floppy_drq,
  input  wire logic        par_drq,
  input  wire logic        floppy_irq,
  input  wire logic        par_irq,
  input  wire logic        ser1_irq,
  input  wire logic        ser2_irq,
  output logic             par_cs,
  output logic             par_upper,
  output logic             ser1_cs,
  output logic             ser2_cs,
  output logic      [3:0]  dma_req,
  output logic      [3:0]  dma_req_oe_n,
  output logic      [15:1] irq_line,
  output logic      [15:1] irq_line_oe_n
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0] index_q;
  logic [7:0] sw_sel_q;
  logic [7:0] par_base_q;
  logic [7:0] ser1_base_q;
  logic [7:0] ser2_base_q;
  logic [7:0] dma_sel_q;
  logic [7:0] irq_sel_q;
  logic [7:0] ser_irq_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rd_valid_q;
  logic [7:0] rd_mux;

  // ************************************************************
  // Access qualification
  // ************************************************************
  // Outside configuration state writes are dropped silently and reads return zero
  wire idx_wr  = io_wr & cfg_state & io_index_sel;          // [RULE_04]
  wire dat_acc = cfg_state & ~io_index_sel;                 // [RULE_04]
  wire dat_wr  = io_wr & dat_acc;

  wire wr_sw   = dat_wr & (index_q == iorm_pkg::IDX_SW_SEL);
  wire wr_par  = dat_wr & (index_q == iorm_pkg::IDX_PAR_BASE);
  wire wr_s1   = dat_wr & (index_q == iorm_pkg::IDX_SER1_BASE);
  wire wr_s2   = dat_wr & (index_q == iorm_pkg::IDX_SER2_BASE);
  wire wr_dma  = dat_wr & (index_q == iorm_pkg::IDX_DMA_SEL);
  wire wr_irq  = dat_wr & (index_q == iorm_pkg::IDX_IRQ_SEL);
  wire wr_sirq = dat_wr & (index_q == iorm_pkg::IDX_SER_IRQ);

  // Reserved bits are masked at the write so they can never read back
  wire [7:0] sw_wdata  = io_wdata & iorm_pkg::SW_SEL_MASK;  // [RULE_02]
  wire [7:0] ser_wdata = io_wdata & iorm_pkg::SER_BASE_MASK; // [RULE_10] [RULE_12]

  // ************************************************************
  // Index register
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      index_q <= iorm_pkg::RST_INDEX;
    end else if (idx_wr) begin
      index_q <= io_wdata;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Index 21 has no storage, so its writes fall away
  always_ff @(posedge clk) begin
    if (srst) begin
      sw_sel_q <= iorm_pkg::RST_SW_SEL;                     // [RULE_02]
    end else if (wr_sw) begin
      sw_sel_q <= sw_wdata;                                 // [RULE_03]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      par_base_q <= iorm_pkg::RST_PAR_BASE;                 // [RULE_14]
    end else if (wr_par) begin
      par_base_q <= io_wdata;                               // [RULE_07]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ser1_base_q <= iorm_pkg::RST_SER1_BASE;               // [RULE_14]
    end else if (wr_s1) begin
      ser1_base_q <= ser_wdata;                             // [RULE_10]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ser2_base_q <= iorm_pkg::RST_SER2_BASE;               // [RULE_14]
    end else if (wr_s2) begin
      ser2_base_q <= ser_wdata;                             // [RULE_12]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dma_sel_q <= iorm_pkg::RST_DMA_SEL;                   // [RULE_14]
    end else if (wr_dma) begin
      dma_sel_q <= io_wdata;                                // [RULE_15]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_sel_q <= iorm_pkg::RST_IRQ_SEL;                   // [RULE_14]
    end else if (wr_irq) begin
      irq_sel_q <= io_wdata;                                // [RULE_17]
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ser_irq_q <= iorm_pkg::RST_SER_IRQ;
    end else if (wr_sirq) begin
      ser_irq_q <= io_wdata;                                // [RULE_20]
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    unique case (index_q)
      iorm_pkg::IDX_SW_SEL:    rd_mux = sw_sel_q;
      iorm_pkg::IDX_PAR_BASE:  rd_mux = par_base_q;
      iorm_pkg::IDX_SER1_BASE: rd_mux = ser1_base_q;
      iorm_pkg::IDX_SER2_BASE: rd_mux = ser2_base_q;
      iorm_pkg::IDX_DMA_SEL:   rd_mux = dma_sel_q;
      iorm_pkg::IDX_IRQ_SEL:   rd_mux = irq_sel_q;
      iorm_pkg::IDX_SER_IRQ:   rd_mux = ser_irq_q;
      default:                 rd_mux = iorm_pkg::RD_ZERO; // [RULE_01]
    endcase
  end

  // Refused reads still answer, with zero, so the master never hangs
  assign rdata_d = !cfg_state   ? iorm_pkg::RD_ZERO :       // [RULE_04]
                   io_index_sel ? index_q : rd_mux;

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q    <= iorm_pkg::RD_ZERO;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= io_rd;
      if (io_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign io_rdata    = rdata_q;
  assign io_rd_valid = rd_valid_q;

  // ************************************************************
  // Decode and routing
  // ************************************************************
  iorm_cfg_if cfg_if ();

  assign cfg_if.par_base    = par_base_q;
  assign cfg_if.ser1_base   = ser1_base_q;
  assign cfg_if.ser2_base   = ser2_base_q;
  assign cfg_if.dma_sel     = dma_sel_q;                    // [RULE_03]
  assign cfg_if.irq_sel     = irq_sel_q;
  assign cfg_if.ser_irq_sel = ser_irq_q;

  iorm_decode u_decode (
    .clk         (clk),
    .srst        (srst),
    .cfg         (cfg_if),
    .cs_n        (chip_select_n),
    .addr        (host_addr),
    .mode        (iorm_pkg::iorm_pmode_t'(par_mode)),
    .par_cs_q    (par_cs),
    .par_upper_q (par_upper),
    .ser1_cs_q   (ser1_cs),
    .ser2_cs_q   (ser2_cs)
  );

  iorm_route u_route (
    .clk        (clk),
    .srst       (srst),
    .cfg        (cfg_if),
    .floppy_drq (floppy_drq),
    .par_drq    (par_drq),
    .floppy_irq (floppy_irq),
    .par_irq    (par_irq),
    .ser1_irq   (ser1_irq),
    .ser2_irq   (ser2_irq),
    .dma_q      (dma_req),
    .dma_oe_n_q (dma_req_oe_n),
    .irq_q      (irq_line),
    .irq_oe_n_q (irq_line_oe_n)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  wire [55:0] all_regs = {sw_sel_q, par_base_q, ser1_base_q,
                          ser2_base_q, dma_sel_q, irq_sel_q, ser_irq_q};

  rsvd_write_a: assert property ( // [RULE_01]
    dat_wr && index_q == iorm_pkg::IDX_RSVD_21
    |=> $stable(all_regs))
    else $error("write to reserved index changed a register");

  rsvd_read_a: assert property ( // [RULE_01]
    io_rd && dat_acc && index_q == iorm_pkg::IDX_RSVD_21
    |=> io_rd_valid && io_rdata == 8'h00)
    else $error("reserved index read not zero");

  sw_rsvd_a: assert property (sw_sel_q[7:6] == 2'h0) // [RULE_02]
    else $error("software select reserved bits set");

  sw_no_route_a: assert property ( // [RULE_03]
    wr_sw |=> $stable(dma_sel_q) && $stable(irq_sel_q))
    else $error("software select write moved routing");

  no_cfg_a: assert property ( // [RULE_04]
    io_wr && !cfg_state |=> $stable(all_regs) && $stable(index_q))
    else $error("write accepted outside configuration state");

  par_store_a: assert property ( // [RULE_07]
    wr_par |=> par_base_q == $past(io_wdata))
    else $error("parallel base write not stored");

  ser_bit0_a: assert property ( // [RULE_10]
    !ser1_base_q[0] && !ser2_base_q[0])
    else $error("serial base bit 0 set");

  reset_zero_a: assert property (disable iff (1'b0) // [RULE_14]
    srst |=> all_regs == 56'h0 && dma_req_oe_n == 4'hF)
    else $error("registers not zero after reset");

  read_lat_a: assert property ( // [RULE_15]
    io_rd && dat_acc && index_q == iorm_pkg::IDX_DMA_SEL
    |=> io_rd_valid && io_rdata == $past(dma_sel_q))
    else $error("DMA select read mismatch");

  idx_load_a: assert property ( // [RULE_04]
    idx_wr |=> index_q == $past(io_wdata))
    else $error("index write not stored");

  idx_keep_a: assert property ( // [RULE_04]
    !idx_wr |=> $stable(index_q))
    else $error("index changed without an index write");

  idx_read_a: assert property ( // [RULE_04]
    io_rd && cfg_state && io_index_sel |=> io_rdata == $past(index_q))
    else $error("index read mismatch");

  rd_refuse_a: assert property ( // [RULE_04]
    io_rd && !cfg_state |=> io_rd_valid && io_rdata == iorm_pkg::RD_ZERO)
    else $error("read outside configuration state not zero");

  sw_store_a: assert property ( // [RULE_02]
    wr_sw |=> sw_sel_q == ($past(io_wdata) & iorm_pkg::SW_SEL_MASK))
    else $error("software select write not stored");

  s1_store_a: assert property ( // [RULE_10]
    wr_s1 |=> ser1_base_q == ($past(io_wdata) & iorm_pkg::SER_BASE_MASK))
    else $error("serial one base write not stored");

  s2_store_a: assert property ( // [RULE_12]
    wr_s2 |=> ser2_base_q == ($past(io_wdata) & iorm_pkg::SER_BASE_MASK))
    else $error("serial two base write not stored");

  dma_store_a: assert property ( // [RULE_15]
    wr_dma |=> dma_sel_q == $past(io_wdata))
    else $error("DMA select write not stored");

  irq_store_a: assert property ( // [RULE_17]
    wr_irq |=> irq_sel_q == $past(io_wdata))
    else $error("interrupt select write not stored");

  sirq_store_a: assert property ( // [RULE_20]
    wr_sirq |=> ser_irq_q == $past(io_wdata))
    else $error("serial interrupt select write not stored");

  dma_route_a: assert property ( // [RULE_15]
    dma_sel_q[3:0] <= iorm_pkg::DMA_CODE_MAX
    |=> !dma_req_oe_n[$past(dma_sel_q[1:0])])
    else $error("selected DMA channel not driven");

  irq_route_a: assert property ( // [RULE_17]
    irq_sel_q[3:0] != 4'h0 |=> !irq_line_oe_n[$past(irq_sel_q[3:0])])
    else $error("selected interrupt line not driven");

  par_cov_c:  cover property (par_cs ##1 !par_cs);
  ser1_cov_c: cover property (ser1_cs && ser2_cs == 1'b0);
  dma_cov_c:  cover property (wr_dma ##2 dma_req_oe_n != 4'hF);
  irq_cov_c:  cover property (wr_sirq ##2 irq_line_oe_n != 15'h7FFF);

endmodule : iorm_top

// file: iorm_host_model.sv
// Purpose: Host bus master issuing configuration I/O cycles
// Assumes: Outputs change on the falling edge of clk
// Notes:   Released write data shows the inverse of its last value
`timescale 1ns/100ps

// ********************************************************
// Host model
// ********************************************************
module iorm_host_model (
  input  wire logic       clk,
  output logic            cfg_state,
  output logic            io_wr,
  output logic            io_rd,
  output logic            io_index_sel,
  output logic [7:0]      io_wdata,
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rd_valid
);
  initial begin
    cfg_state    = 1'h0;
    io_wr        = 1'h0;
    io_rd        = 1'h0;
    io_index_sel = 1'h0;
    io_wdata     = 8'h00;
  end

  task automatic set_cfg(input logic en);
    @(negedge clk);
    cfg_state = en;
  endtask : set_cfg

  // Index always loaded before the data access
  task automatic put_index(input logic [7:0] idx);
    @(negedge clk);
    io_index_sel = 1'h1;
    io_wr        = 1'h1;
    io_wdata     = idx;
  endtask : put_index

  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] d);
    put_index(idx);
    @(negedge clk);
    io_index_sel = 1'h0;
    io_wdata     = d;
    // Serial bases get bit 0 written as zero
    if (idx == 8'h24 || idx == 8'h25) io_wdata[0] = 1'h0;
    @(negedge clk);
    io_wr    = 1'h0;
    io_wdata = ~io_wdata;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] idx, output logic [7:0] d,
                          output logic vld);
    put_index(idx);
    @(negedge clk);
    io_wr        = 1'h0;
    io_index_sel = 1'h0;
    io_wdata     = ~idx;
    io_rd        = 1'h1;
    @(negedge clk);
    io_rd = 1'h0;
    d     = io_rdata;
    vld   = io_rd_valid;
  endtask : cfg_read
endmodule : iorm_host_model

// file: test_io_resource_map_config.sv
// Purpose: Self-checking bench of the I/O resource map registers
// Assumes: Inputs driven on the falling edge, outputs registered
// Notes:   Fixed seed, so every run repeats the same stimulus
`timescale 1ns/100ps

module test_io_resource_map_config;
  logic        clk = 1'h0;
  logic        srst = 1'h1;
  logic        cfg_state, io_wr, io_rd, io_index_sel, io_rd_valid, vld;
  logic [7:0]  io_wdata, io_rdata, rd_d;
  logic        chip_select_n = 1'h1;
  logic [10:2] host_addr = 9'h000;
  logic [1:0]  par_mode = 2'h0;
  logic        fd = 1'h0, pd = 1'h0;
  logic [3:0]  rq = 4'h0;
  logic        par_cs, par_upper, ser1_cs, ser2_cs;
  logic [3:0]  dma_req, dma_req_oe_n;
  logic [15:1] irq_line, irq_line_oe_n;
  logic [7:0]  bases [3];
  int          n_errors = 0;
  int          checks = 0;
  int          cycles = 0;

  always #10 clk = ~clk;

  iorm_host_model host_u (.clk(clk), .cfg_state(cfg_state), .io_wr(io_wr),
    .io_rd(io_rd), .io_index_sel(io_index_sel), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_rd_valid(io_rd_valid));

  iorm_top dut_u (.clk(clk), .srst(srst), .cfg_state(cfg_state),
    .io_wr(io_wr), .io_rd(io_rd), .io_index_sel(io_index_sel),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
    .chip_select_n(chip_select_n), .host_addr(host_addr),
    .par_mode(par_mode), .floppy_drq(fd), .par_drq(pd),
    .floppy_irq(rq[3]), .par_irq(rq[2]), .ser1_irq(rq[1]),
    .ser2_irq(rq[0]), .par_cs(par_cs), .par_upper(par_upper),
    .ser1_cs(ser1_cs), .ser2_cs(ser2_cs), .dma_req(dma_req),
    .dma_req_oe_n(dma_req_oe_n), .irq_line(irq_line),
    .irq_line_oe_n(irq_line_oe_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    host_u.cfg_read(idx, rd_d, vld);
    check({24'h0, rd_d}, {24'h0, exp});
    check({31'h0, vld}, 32'h1);
  endtask : rd_chk

  function automatic logic ser_hit(input logic [7:0] b, input logic csn,
                                   input logic [10:2] a);
    return b[7:6] != 2'h0 && !csn && !a[10] && a[9:3] == b[7:1];
  endfunction : ser_hit

  function automatic logic [3:0] exp_dec(input logic [1:0] m,
                                         input logic csn,
                                         input logic [10:2] a);
    logic ph;
    ph = bases[0][7:6] != 2'h0 && !csn &&
         (m == 2'h2 ? a[9:3] == bases[0][7:1] : a[9:2] == bases[0]);
    return {ph && (m == 2'h3 || !a[10]), ph && m == 2'h3 && a[10],
            ser_hit(bases[1], csn, a), ser_hit(bases[2], csn, a)};
  endfunction : exp_dec

  function automatic logic [29:0] exp_route(input logic [15:0] c,
                                            input logic [3:0] r,
                                            input logic dma);
    logic [15:1] oe_n;
    logic [15:1] v;
    oe_n = 15'h7FFF;
    v    = 15'h0000;
    for (int k = 0; k < 4; k++) begin
      if (dma ? c[4*k +: 4] < 4'h4 : c[4*k +: 4] != 4'h0) begin
        oe_n[c[4*k +: 4] + dma] = 1'h0;
        v[c[4*k +: 4] + dma]    = v[c[4*k +: 4] + dma] | r[k];
      end
    end
    return {oe_n, v};
  endfunction : exp_route

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    logic [7:0]  v;
    logic [15:0] c;
    logic [3:0]  m;
    logic [29:0] e;
    void'($urandom(91016));
    repeat (5) @(negedge clk);
    srst = 1'h0;
    host_u.set_cfg(1'h1);
    for (int i = 8'h22; i < 8'h29; i++) rd_chk(8'(i), 8'h00);
    check({17'h0, irq_line_oe_n}, 32'h7FFF);
    host_u.cfg_write(8'h21, 8'hFF);
    rd_chk(8'h21, 8'h00);
    v = 8'($urandom);
    host_u.cfg_write(8'h22, v | 8'h38);
    rd_chk(8'h22, (v | 8'h38) & 8'h3F);
    check({17'h0, irq_line_oe_n}, 32'h7FFF);
    host_u.cfg_write(8'h23, 8'hA5);
    host_u.set_cfg(1'h0);
    host_u.cfg_write(8'h23, 8'h5A);
    rd_chk(8'h23, 8'h00);
    host_u.set_cfg(1'h1);
    rd_chk(8'h23, 8'hA5);
    // Decode: first round with all ports disabled, hits forced often
    for (int i = 0; i < 200; i++) begin
      if (i % 40 == 0) begin
        for (int k = 0; k < 3; k++) begin
          bases[k] = 8'($urandom);
          if (i == 0) bases[k][7:6] = 2'h0;
          if (k > 0) bases[k][0] = 1'h0;
          host_u.cfg_write(8'(8'h23 + k), bases[k]);
        end
      end
      m = 4'($urandom_range(0, 3));
      host_addr = 9'($urandom);
      if (m < 4'h3) host_addr[9:2] = bases[m] ^ 8'($urandom_range(0, 1));
      host_addr[10] = $urandom_range(0, 3) == 0;
      chip_select_n = $urandom_range(0, 5) == 0;
      par_mode = 2'($urandom);
      @(negedge clk);
      e = {26'h0, exp_dec(par_mode, chip_select_n, host_addr)};
      check({31'h0, par_cs}, {31'h0, e[3]});
      check({31'h0, par_upper}, {31'h0, e[2]});
      check({30'h0, ser1_cs, ser2_cs}, {30'h0, e[1:0]});
    end
    // Every DMA and IRQ code on the floppy nibble, reversed on serial two, random on the others
    for (int i = 0; i < 16; i++) begin
      c = {4'(i), 4'($urandom), 4'($urandom), 4'(15 - i)};
      host_u.cfg_write(8'h26, c[15:8]);
      fd = 1'($urandom);
      pd = 1'($urandom);
      @(negedge clk);
      e = exp_route({8'hFF, c[15:8]}, {2'h0, fd, pd}, 1'h1);
      check({28'h0, dma_req_oe_n}, {28'h0, e[18:15]});
      check({28'h0, dma_req}, {28'h0, e[3:0]});
      host_u.cfg_write(8'h27, c[15:8]);
      host_u.cfg_write(8'h28, c[7:0]);
      rq = 4'($urandom);
      @(negedge clk);
      e = exp_route(c, rq, 1'h0);
      check({17'h0, irq_line_oe_n}, {17'h0, e[29:15]});
      check({17'h0, irq_line}, {17'h0, e[14:0]});
    end
    finish_test();
  end
endmodule : test_io_resource_map_config
